// >>> bench/lpsc_host.sv
// host model driving command bytes
`timescale 1ns/1ps
module lpsc_host(input logic MCLK, output logic CMD_WRITE,
  output logic [7:0] CMD_DATA);
  initial {CMD_WRITE, CMD_DATA} = 9'h0;
  task automatic send(input logic [7:0] b);
    CMD_WRITE <= 1'b1;
    CMD_DATA <= b;
    @(posedge MCLK);
  endtask
  // released data turns over, never a stale byte
  task automatic idle;
    CMD_WRITE <= 1'b0;
    CMD_DATA <= ~CMD_DATA;
  endtask
endmodule

// >>> bench/lpsc_props.sv
// lcd supply control checker
`timescale 1ns/1ps
module lpsc_props(input logic MCLK, RST, CMD_WRITE, MASTER_SELECT,
  FEEDBACK_INPUT_ENABLE, INTERNAL_RESISTOR_STRAP, REFERENCE_SOURCE_STRAP,
  HIGH_POWER_SELECT_N, BIAS_SELECT, input logic [7:0] CMD_DATA,
  input logic [5:0] CONTRAST_LEVEL, input logic [2:0] REGULATOR_GAIN_RATIO,
  input lpsc_pkg::lpsc_stages_type STAGE_ENABLE,
  input lpsc_pkg::lpsc_analog_mode_type ANALOG_MODE);
  logic vp;
  wire [3:0] sm = {INTERNAL_RESISTOR_STRAP, REFERENCE_SOURCE_STRAP,
    !HIGH_POWER_SELECT_N, BIAS_SELECT};
  wire pw = CMD_WRITE && !vp;
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  // next byte is owed to the level
  always_ff @(posedge MCLK or posedge RST)
    if (RST) vp <= 1'b0;
    else if (CMD_WRITE) vp <= CMD_DATA == 8'h81 && !vp;
  a_reset_dflt: assert property ($fell(RST) |->
    STAGE_ENABLE == 3'h0 && CONTRAST_LEVEL == 6'h20 &&
    REGULATOR_GAIN_RATIO == 3'h4) else $error("reset");
  a_slave_off: assert property ((!MASTER_SELECT)[*3] |=>
    STAGE_ENABLE == 3'h0) else $error("slave");
  a_power_set: assert property (MASTER_SELECT[*3] ##0
    (pw && CMD_DATA[7:3] == 5'h05) |=> STAGE_ENABLE == $past(CMD_DATA[2:0]))
    else $error("power");
  a_ratio_set: assert property (pw && CMD_DATA[7:3] == 5'h04 |=>
    REGULATOR_GAIN_RATIO == $past(CMD_DATA[2:0])) else $error("ratio");
  a_soft_ratio: assert property (pw && CMD_DATA == 8'he2 |=>
    REGULATOR_GAIN_RATIO == 3'h4) else $error("soft");
  a_level_set: assert property (CMD_WRITE && vp |=>
    CONTRAST_LEVEL == $past(CMD_DATA[5:0])) else $error("level");
  a_idle_hold: assert property (!CMD_WRITE |=>
    $stable(CONTRAST_LEVEL)) else $error("hold");
  a_strap_mode: assert property (
    $stable(sm)[*4] |=> ANALOG_MODE == $past(sm) &&
    FEEDBACK_INPUT_ENABLE == !$past(sm[3])) else $error("strap");
  cover property (CMD_WRITE && vp);
  cover property (!MASTER_SELECT && CMD_WRITE);
  cover property (pw && CMD_DATA == 8'he2);
endmodule
bind lpsc_power_control lpsc_props chk(.*);

// >>> bench/testbench.sv
// self-checking bench for lcd supply control
`timescale 1ns/1ps
module testbench;
  logic MCLK = 0, RST = 1, MASTER_SELECT = 1, CMD_WRITE, FEEDBACK_INPUT_ENABLE;
  logic [7:0] CMD_DATA, lf = 8'h38;
  logic [5:0] CONTRAST_LEVEL, c = 6'h20;
  logic [2:0] REGULATOR_GAIN_RATIO, s = 3'h0, r = 3'h4;
  logic [3:0] sp = 4'h0;
  wire INTERNAL_RESISTOR_STRAP = sp[3], REFERENCE_SOURCE_STRAP = sp[2];
  wire HIGH_POWER_SELECT_N = sp[1], BIAS_SELECT = sp[0];
  lpsc_pkg::lpsc_stages_type STAGE_ENABLE;
  lpsc_pkg::lpsc_analog_mode_type ANALOG_MODE;
  logic [16:0] q[$];
  int n_mismatch = 0, checked = 0;
  lpsc_host host(.*);
  lpsc_power_control dut(.*);
  initial forever #2.5 MCLK = ~MCLK;
  function automatic logic [7:0] nx(input logic [7:0] v);
    return {v[6:0], ^(v & 8'hb8)};
  endfunction
  task automatic chk(input logic [16:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %h not %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("%0d checks %0d mismatches", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic note;
    q.push_back({RST ? 5'h00 : {~sp[3], sp ^ 4'h2},
      s & {3{MASTER_SELECT}}, c, r});
  endtask
  task automatic cmd(input logic [7:0] b);
    host.send(b);
    note;
  endtask
  always @(negedge MCLK)
    if (q.size() > 0) chk({FEEDBACK_INPUT_ENABLE, ANALOG_MODE, STAGE_ENABLE,
      CONTRAST_LEVEL, REGULATOR_GAIN_RATIO}, q.pop_front());
  initial begin
    note;
    repeat (10) @(posedge MCLK);
    RST <= 0;
    sp <= lf[3:0];
    repeat (4) @(posedge MCLK);
    note;
    for (int i = 0; i < 8; i++) begin
      s = i[2:0];
      cmd({5'h05, s});
      r = ~s;
      cmd({5'h04, r});
    end
    for (int i = 0; i < 3; i++) begin
      lf = nx(lf);
      cmd(8'h81);
      c = i == 1 ? 6'h01 : lf[5:0];
      cmd(i == 1 ? 8'h81 : lf);
    end
    r = 3'h4;
    cmd(8'he2);
    host.idle;
    MASTER_SELECT <= 0;
    repeat (4) @(posedge MCLK);
    cmd(8'h2d);
    host.idle;
    s = 3'h5;
    MASTER_SELECT <= 1;
    lf = nx(lf);
    sp <= lf[3:0];
    repeat (4) @(posedge MCLK);
    note;
    repeat (2) @(posedge MCLK);
    s = 3'h0;
    cmd(8'h28);
    host.idle;
    repeat (2) @(posedge MCLK);
    $display("settings and straps test done");
    stop_test;
  end
  initial begin
    #5000;
    n_mismatch++;
    stop_test;
  end
endmodule

// >>> common/lpsc_params.svh
// constants for the lcd power supply control block
`ifndef LPSC_PARAMS_SVH
`define LPSC_PARAMS_SVH
`define LPSC_CMD_POWER 8'h28
`define LPSC_CMD_POWER_MASK 8'hf8
`define LPSC_CMD_RATIO 8'h20
`define LPSC_CMD_RATIO_MASK 8'hf8
`define LPSC_CMD_VOLUME 8'h81
`define LPSC_CMD_RESET 8'he2
`define LPSC_POWER_RESET 3'h0
`define LPSC_VOLUME_RESET 6'h20
`define LPSC_RATIO_RESET 3'h4
`define LPSC_POWER_BOOST_BIT 2
`define LPSC_POWER_REG_BIT 1
`define LPSC_POWER_FOLLOW_BIT 0
`endif

// >>> common/lpsc_pkg.sv
// types for the lcd power supply control block
package lpsc_pkg;
  typedef struct packed {
    logic booster_on;
    logic regulator_on;
    logic follower_on;
  } lpsc_stages_type;

  typedef struct packed {
    logic use_internal_resistors;
    logic use_internal_reference;
    logic high_power;
    logic bias_one_seventh;
  } lpsc_analog_mode_type;

  typedef enum logic [1:0] {
    LPSC_IDLE,
    LPSC_WAIT_VOLUME
  } lpsc_state_type;
endpackage

// >>> rtl/lpsc_power_control.sv
// lcd power supply control: command decode, settings and stage enables
`timescale 1ns/1ps
`include "lpsc_params.svh"
module lpsc_power_control (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic CMD_WRITE,
  input wire logic [7:0] CMD_DATA,
  input wire logic MASTER_SELECT,
  input wire logic INTERNAL_RESISTOR_STRAP,
  input wire logic REFERENCE_SOURCE_STRAP,
  input wire logic HIGH_POWER_SELECT_N,
  input wire logic BIAS_SELECT,
  output lpsc_pkg::lpsc_stages_type STAGE_ENABLE,
  output logic [5:0] CONTRAST_LEVEL,
  output logic [2:0] REGULATOR_GAIN_RATIO,
  output lpsc_pkg::lpsc_analog_mode_type ANALOG_MODE,
  output logic FEEDBACK_INPUT_ENABLE
);
  // command strobe and data come from the host logic on this clock;
  // straps are pads and pass two flops before any logic reads them
  localparam int STRAP_COUNT = 5;
  localparam int STAGE_COUNT = 3;

  logic [STRAP_COUNT-1:0] strap_pins;
  logic [STRAP_COUNT-1:0] strap_meta;
  logic [STRAP_COUNT-1:0] strap_sync;

  logic master_synced;
  logic internal_resistor_synced;
  logic reference_source_synced;
  logic high_power_select_n_synced;
  logic bias_synced;

  logic is_power_cmd;
  logic is_ratio_cmd;
  logic is_volume_cmd;
  logic is_soft_reset_cmd;

  logic level_byte_due;
  logic cmd_taken_opcode;
  logic cmd_taken_level;

  logic [2:0] power_stage_switches;
  logic [5:0] contrast_level;
  logic [2:0] regulator_gain_ratio;
  lpsc_pkg::lpsc_state_type state;

  logic [2:0] next_power_stage_switches;
  logic [5:0] next_contrast_level;
  logic [2:0] next_regulator_gain_ratio;
  lpsc_pkg::lpsc_state_type next_state;

  logic [STAGE_COUNT-1:0] next_stage_bits;

  lpsc_pkg::lpsc_stages_type next_stage_enable;
  lpsc_pkg::lpsc_analog_mode_type next_analog_mode;
  logic next_feedback_enable;

  // masked opcode compare for commands that carry data in low bits
  function automatic logic cmd_match(
    input logic [7:0] d,
    input logic [7:0] code,
    input logic [7:0] mask
  );
    cmd_match = (d & mask) == code;
  endfunction

  // exact compare for opcodes that carry no data bits
  function automatic logic cmd_equal(
    input logic [7:0] d,
    input logic [7:0] code
  );
    cmd_equal = d == code;
  endfunction

  // a stage runs only with its bit set and this chip the master
  function automatic logic stage_gate(
    input logic bit_on,
    input logic master
  );
    stage_gate = bit_on & master;
  endfunction

  // order matches the bit positions read out below
  assign strap_pins = {
    MASTER_SELECT,
    INTERNAL_RESISTOR_STRAP,
    REFERENCE_SOURCE_STRAP,
    HIGH_POWER_SELECT_N,
    BIAS_SELECT
  };

  // only the second flop of each pair feeds logic
  for (genvar i = 0; i < STRAP_COUNT; i++) begin : g_strap_sync
    always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
        strap_meta[i] <= 1'b0;
        strap_sync[i] <= 1'b0;
      end else begin
        strap_meta[i] <= strap_pins[i];
        strap_sync[i] <= strap_meta[i];
      end
    end
  end

  assign master_synced = strap_sync[4];
  assign internal_resistor_synced = strap_sync[3];
  assign reference_source_synced = strap_sync[2];
  assign high_power_select_n_synced = strap_sync[1];
  assign bias_synced = strap_sync[0];

  always_comb begin
    level_byte_due = state == lpsc_pkg::LPSC_WAIT_VOLUME;

    is_power_cmd = cmd_match(CMD_DATA, `LPSC_CMD_POWER,
      `LPSC_CMD_POWER_MASK);

    is_ratio_cmd = cmd_match(CMD_DATA, `LPSC_CMD_RATIO,
      `LPSC_CMD_RATIO_MASK);

    is_volume_cmd = cmd_equal(CMD_DATA, `LPSC_CMD_VOLUME);

    is_soft_reset_cmd = cmd_equal(CMD_DATA, `LPSC_CMD_RESET);

    cmd_taken_opcode = CMD_WRITE && !level_byte_due;
    cmd_taken_level = CMD_WRITE && level_byte_due;
  end

  // volume is two bytes; the byte after the opcode is always the level
  always_comb begin
    next_state = state;

    if (CMD_WRITE) begin
      case (state)
        lpsc_pkg::LPSC_IDLE: begin
          if (is_volume_cmd) begin
            next_state = lpsc_pkg::LPSC_WAIT_VOLUME;
          end
        end

        lpsc_pkg::LPSC_WAIT_VOLUME: begin
          next_state = lpsc_pkg::LPSC_IDLE;
        end

        // unknown state codes fall back to idle
        default: begin
          next_state = lpsc_pkg::LPSC_IDLE;
        end
      endcase
    end
  end

  // any pattern is stored, recommended or not
  always_comb begin
    next_power_stage_switches = power_stage_switches;

    if (cmd_taken_opcode && is_power_cmd) begin
      next_power_stage_switches = CMD_DATA[2:0];
    end
  end

  always_comb begin
    next_regulator_gain_ratio = regulator_gain_ratio;

    if (cmd_taken_opcode && is_ratio_cmd) begin
      next_regulator_gain_ratio = CMD_DATA[2:0];
    end else if (cmd_taken_opcode && is_soft_reset_cmd) begin
      // soft reset restores the ratio only; power bits and level stay
      next_regulator_gain_ratio = `LPSC_RATIO_RESET;
    end
  end

  always_comb begin
    next_contrast_level = contrast_level;

    if (cmd_taken_level) begin
      next_contrast_level = CMD_DATA[5:0];
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      state <= lpsc_pkg::LPSC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // hardware reset turns every stage off
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      power_stage_switches <= `LPSC_POWER_RESET;
    end else begin
      power_stage_switches <= next_power_stage_switches;
    end
  end

  // ratio comes up as binary 100
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      regulator_gain_ratio <= `LPSC_RATIO_RESET;
    end else begin
      regulator_gain_ratio <= next_regulator_gain_ratio;
    end
  end

  // level 32 after a hardware reset
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      contrast_level <= `LPSC_VOLUME_RESET;
    end else begin
      contrast_level <= next_contrast_level;
    end
  end

  // enables follow the next value so they change with the write edge
  for (genvar b = 0; b < STAGE_COUNT; b++) begin : g_stage_gate
    assign next_stage_bits[b] = stage_gate(
      next_power_stage_switches[b], master_synced);
  end

  always_comb begin
    next_stage_enable.booster_on = next_stage_bits[`LPSC_POWER_BOOST_BIT];
    next_stage_enable.regulator_on = next_stage_bits[`LPSC_POWER_REG_BIT];
    next_stage_enable.follower_on =
      next_stage_bits[`LPSC_POWER_FOLLOW_BIT];
  end

  always_comb begin
    next_analog_mode.use_internal_resistors = internal_resistor_synced;

    next_analog_mode.use_internal_reference =
      reference_source_synced;

    next_analog_mode.high_power =
      ~high_power_select_n_synced;

    next_analog_mode.bias_one_seventh =
      bias_synced;
  end

  // the feedback pin only counts while the internal resistors are off
  always_comb begin
    next_feedback_enable = ~internal_resistor_synced;
  end

  // registered outputs keep the analog controls free of decode glitches
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      STAGE_ENABLE <= '0;
    end else begin
      STAGE_ENABLE <= next_stage_enable;
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      CONTRAST_LEVEL <= `LPSC_VOLUME_RESET;
    end else begin
      CONTRAST_LEVEL <= next_contrast_level;
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      REGULATOR_GAIN_RATIO <= `LPSC_RATIO_RESET;
    end else begin
      REGULATOR_GAIN_RATIO <= next_regulator_gain_ratio;
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ANALOG_MODE <= '0;
    end else begin
      ANALOG_MODE <= next_analog_mode;
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      FEEDBACK_INPUT_ENABLE <= 1'b0;
    end else begin
      FEEDBACK_INPUT_ENABLE <= next_feedback_enable;
    end
  end
endmodule
